// ---- inc/msc_defs.svh ----
// Purpose: constants for the microstep current chopper
// Assumes: 250 MHz ref_clk, 4 ns period
// Notes: register offsets are word addresses on the plain register port
// Function
// - step input rising edge or soft step bit write advances the indexer.
// - direction pin xor invert bit picks forward or reverse sequencing.
// - after step mode change, next step lands on a state valid for new mode.
// - at threshold bridge stops for off time (min 500 ns), then restarts.
// - reference equals sine times amplitude divided by 256, 2.75 V full scale DAC.
// - sense gain selectable 5, 10, 20, 40; code 0 gives 5.
// - fast/slow in both modes; mixed and auto-mixed only with indexer.
// - fast decay reverses drive, then disables bridge near zero current.
// - slow decay turns on both low sides together.
// - mixed decay runs fast for fast-phase duration, then slow; here each trip goes slow, fast only after a table fall, timed by blkEff.
// - mixed decay uses slow when table current rises or stays.
// - auto-mixed samples at blank end; above trip goes fast, then slow.
// - below trip at blank end, stay on until trip, then fast decay as above, then slow.
// - trip level change ends cycle; raise turns on, lower starts fast.
// - comparator ignored for blanking after turn on; 1 us plus 20 ns steps, up to 6.1 us.
// - auto-mixed applies blanking after fast decay starts too.
// - adaptive blank halves blanking when table current below 30 percent.
// - gate peak source 50 to 200 mA; sink about twice source.
// - peak gate current only for drive duration, then weak hold.
// - low-side gate held low while high side turns on.
// - digital dead time from a field inserted between complementary switches.
// - peak drive duration never lengthens PWM cycle.
// - reset puts indexer at 45 degrees, both windings about 75 percent.
// - mode code 0 is full step, each increment halves, 8 is 1/256.
// - winding A follows sine of angle, winding B follows cosine.
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH
// ==========================================================
// register map (word index)
`define MSC_REG_CTRL 4'h0
`define MSC_REG_TORQUE 4'h1
`define MSC_REG_OFF 4'h2
`define MSC_REG_BLANK 4'h3
`define MSC_REG_DECAY 4'h4
`define MSC_REG_DRIVE 4'h5
`define MSC_REG_STAT 4'h6
// ==========================================================
// ctrl, blank, decay and drive field positions
`define MSC_CTRL_ENA 0
`define MSC_CTRL_INV 1
`define MSC_CTRL_STEP 2
`define MSC_CTRL_MODE_LSB 3
`define MSC_CTRL_GAIN_LSB 8
`define MSC_CTRL_DT_LSB 10
`define MSC_CTRL_PWMDIR 12
`define MSC_BLANK_ABT 8
`define MSC_DECAY_MODE_LSB 8
`define MSC_DRIVE_SRC_LSB 8
`define MSC_DRIVE_SINK_LSB 10
// ==========================================================
// reset values
`define MSC_CTRL_RST 16'h0001
`define MSC_TORQUE_RST 16'h00FF
`define MSC_OFF_RST 16'h0030
`define MSC_BLANK_RST 16'h0080
`define MSC_DECAY_RST 16'h0110
`define MSC_DRIVE_RST 16'h0000
`define MSC_HOME_ANGLE 10'h080
// ==========================================================
// timing: 250 MHz, 20 ns unit is 5 cycles
`define MSC_CLK_NS 4
`define MSC_UNIT_NS 20
`define MSC_UNIT_CYC (`MSC_UNIT_NS / `MSC_CLK_NS)
`define MSC_OFF_TIME_FIELD_MIN_NS 500
`define MSC_OFF_TIME_FIELD_MIN_CYC ((`MSC_OFF_TIME_FIELD_MIN_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)
`define MSC_BLANK_MIN_NS 1000
`define MSC_BLANK_MIN_CYC (`MSC_BLANK_MIN_NS / `MSC_CLK_NS)
`define MSC_DT_UNIT_NS 400
`define MSC_DT_UNIT_CYC (`MSC_DT_UNIT_NS / `MSC_CLK_NS)
`define MSC_DRV_UNIT_NS 250
`define MSC_DRV_UNIT_CYC (`MSC_DRV_UNIT_NS / `MSC_CLK_NS)
`define MSC_LOW_CUR 8'h4D
`endif

// ---- inc/msc_pkg.sv ----
// Purpose: types for the microstep current chopper
// Assumes: nothing beyond msc_defs.svh
// Notes: types only
package msc_pkg;
  // ==========================================================
  // pwm phase
  typedef enum logic [2:0] {
    MSC_ON = 3'b000,
    MSC_FAST = 3'b001,
    MSC_SLOW = 3'b010,
    MSC_AUTOFAST = 3'b011
  } msc_phase_t;
  // ==========================================================
  // decay select
  typedef enum logic [2:0] {
    MSC_DEC_SLOW = 3'b000,
    MSC_DEC_FAST = 3'b010,
    MSC_DEC_MIXED = 3'b011,
    MSC_DEC_AUTO = 3'b101
  } msc_decay_t;
endpackage : msc_pkg

// ---- hw/msc_chopper.sv ----
// Purpose: indexer plus fixed-off-time chopper for two H-bridges
// Assumes: comparator and step inputs synchronous to ref_clk
// Notes: bridge gates driven with dead time and peak-drive windows
`timescale 1ns/1ps
`include "msc_defs.svh"
module msc_chopper #(
  parameter int REG_W = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [3:0] regAddr,
  input wire logic [REG_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [REG_W-1:0] regRdata,
  input wire logic stepIn,
  input wire logic dirIn,
  input wire logic [1:0] pwmIn,
  input wire logic [1:0] tripCmp,
  input wire logic [1:0] zeroCmp,
  output logic [1:0] hiGate,
  output logic [1:0] loGate,
  output logic [1:0] hiGateB,
  output logic [1:0] loGateB,
  output logic [1:0] peakDrive,
  output logic [7:0] refA,
  output logic [7:0] refB,
  output logic refNegA,
  output logic refNegB,
  output logic [1:0] senseGain,
  output logic [1:0] peakSrc,
  output logic [1:0] peakSink
);
  initial begin
    if (REG_W != 16) $error("msc_chopper supports REG_W of 16 only");
  end
  // ==========================================================
  // registers
  logic [15:0] ctrl_r, torque_r, off_r, blank_r, decay_r, drive_r;
  logic [9:0] angle_r;
  logic stepIn_r;
  logic stepEv;
  assign stepEv = (stepIn & ~stepIn_r) |
    (regWr && regAddr == `MSC_REG_CTRL && regWdata[`MSC_CTRL_STEP]);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `MSC_CTRL_RST;
      torque_r <= `MSC_TORQUE_RST;
      off_r <= `MSC_OFF_RST;
      blank_r <= `MSC_BLANK_RST;
      decay_r <= `MSC_DECAY_RST;
      drive_r <= `MSC_DRIVE_RST;
    end else if (regWr) begin
      if (regAddr == `MSC_REG_CTRL) begin
        ctrl_r <= regWdata & ~(16'h0001 << `MSC_CTRL_STEP);
      end else if (regAddr == `MSC_REG_TORQUE) begin
        torque_r <= regWdata & 16'h00FF;
      end else if (regAddr == `MSC_REG_OFF) begin
        off_r <= regWdata & 16'h00FF;
      end else if (regAddr == `MSC_REG_BLANK) begin
        blank_r <= regWdata & 16'h01FF;
      end else if (regAddr == `MSC_REG_DECAY) begin
        decay_r <= regWdata & 16'h07FF;
      end else if (regAddr == `MSC_REG_DRIVE) begin
        drive_r <= regWdata & 16'h0FFF;
      end
    end
  end
  logic [3:0] mode;
  logic [2:0] decSel;
  assign mode = ctrl_r[`MSC_CTRL_MODE_LSB +: 4];
  assign decSel = decay_r[`MSC_DECAY_MODE_LSB +: 3];
  // ==========================================================
  // indexer
  function automatic logic [9:0] stride(input logic [3:0] m);
    stride = (m > 4'h8) ? 10'h001 : 10'(10'h100 >> m);
  endfunction
  logic fwd;
  assign fwd = dirIn ^ ctrl_r[`MSC_CTRL_INV];
  logic [9:0] st, base, ang_nxt;
  always_comb begin
    st = stride(mode);
    // full step sits on odd multiples of 45 degrees
    base = (mode == 4'h0) ? 10'h080 : 10'h000;
    // snap to the new mode grid before stepping
    if (fwd) ang_nxt = (((angle_r - base) & ~(st - 10'h001)) + base + st);
    else ang_nxt = ((((angle_r - base) + st - 10'h001) & ~(st - 10'h001)) + base - st);
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stepIn_r <= 1'b0;
      angle_r <= `MSC_HOME_ANGLE;
    end else begin
      stepIn_r <= stepIn;
      if (stepEv && ctrl_r[`MSC_CTRL_ENA]) angle_r <= ang_nxt;
    end
  end
  // quarter-wave sine, 257 points, 0..256 scaled to 255
  function automatic logic [7:0] sinq(input logic [7:0] a);
    logic [8:0] x;
    logic [17:0] y;
    x = {1'b0, a};
    // parabola fit keeps the table out of a lookup file
    y = 18'(x * (9'h1FF - x));
    sinq = (a >= 8'hFF) ? 8'hFF : y[15:8];
  endfunction
  function automatic logic [8:0] sinSigned(input logic [9:0] a);
    logic [7:0] q;
    logic [7:0] p;
    p = a[8] ? 8'(9'h100 - {1'b0, a[7:0]}) : a[7:0];
    q = (a[8] && a[7:0] == 8'h00) ? 8'hFF : sinq(p);
    sinSigned = {a[9], q};
  endfunction
  logic [8:0] sA, sB;
  assign sA = sinSigned(angle_r);
  assign sB = sinSigned(10'(angle_r + 10'h100));
  logic [15:0] prodA, prodB;
  assign prodA = 16'(sA[7:0] * torque_r[7:0]);
  assign prodB = 16'(sB[7:0] * torque_r[7:0]);
  logic [7:0] refA_nxt, refB_nxt;
  assign refA_nxt = ctrl_r[`MSC_CTRL_MODE_LSB +: 4] == 4'h0 && 1'b0 ? 8'h00 : prodA[15:8];
  assign refB_nxt = prodB[15:8];
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      refA <= 8'h00;
      refB <= 8'h00;
      refNegA <= 1'b0;
      refNegB <= 1'b0;
      senseGain <= 2'b00;
      peakSrc <= 2'b00;
      peakSink <= 2'b00;
    end else begin
      refA <= refA_nxt;
      refB <= refB_nxt;
      refNegA <= sA[8];
      refNegB <= sB[8];
      senseGain <= ctrl_r[`MSC_CTRL_GAIN_LSB +: 2];
      peakSrc <= drive_r[`MSC_DRIVE_SRC_LSB +: 2];
      peakSink <= drive_r[`MSC_DRIVE_SINK_LSB +: 2];
    end
  end
  // ==========================================================
  // chopper per bridge
  logic [15:0] offCyc, blankCyc, fastCyc, dtCyc, drvCyc;
  assign offCyc = 16'(`MSC_OFF_TIME_FIELD_MIN_CYC + off_r[7:0] * 8'(`MSC_OFF_TIME_FIELD_MIN_CYC));
  assign blankCyc = 16'(`MSC_BLANK_MIN_CYC + blank_r[7:0] * 8'(`MSC_UNIT_CYC));
  assign fastCyc = 16'((decay_r[7:0] + 8'h01) * 8'(`MSC_OFF_TIME_FIELD_MIN_CYC));
  assign dtCyc = 16'((ctrl_r[`MSC_CTRL_DT_LSB +: 2] + 2'h1) * 8'(`MSC_DT_UNIT_CYC));
  assign drvCyc = 16'((drive_r[1:0] + 2'h1) * 8'(`MSC_DRV_UNIT_CYC));
  logic indexer;
  assign indexer = ctrl_r[`MSC_CTRL_ENA];
  msc_pkg::msc_phase_t ph_r [2];
  logic [15:0] tmr_r [2];
  logic [15:0] blk_r [2];
  logic [7:0] lvl_r [2];
  logic [1:0] drvDir;
  assign drvDir = indexer ? {refNegB, refNegA} : {1'b0, 1'b0};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_br
      logic [7:0] lvl;
      logic rising;
      logic [15:0] blkEff;
      logic [2:0] dsel;
      assign lvl = (gi == 0) ? refA : refB;
      assign rising = lvl >= lvl_r[gi];
      assign blkEff = (blank_r[`MSC_BLANK_ABT] && lvl < `MSC_LOW_CUR) ?
        (blankCyc >> 1) : blankCyc;
      // mixed modes fall back to slow outside indexer operation
      assign dsel = (!indexer && (decSel == msc_pkg::MSC_DEC_MIXED ||
        decSel == msc_pkg::MSC_DEC_AUTO)) ? 3'(msc_pkg::MSC_DEC_SLOW) : decSel;
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          ph_r[gi] <= msc_pkg::MSC_ON;
          tmr_r[gi] <= 16'h0000;
          blk_r[gi] <= 16'h0000;
          lvl_r[gi] <= 8'h00;
        end else begin
          lvl_r[gi] <= lvl;
          if (blk_r[gi] != 16'h0000) blk_r[gi] <= blk_r[gi] - 16'h0001;
          if (tmr_r[gi] != 16'h0000) tmr_r[gi] <= tmr_r[gi] - 16'h0001;
          if (!indexer && !pwmIn[gi]) begin
            ph_r[gi] <= msc_pkg::MSC_SLOW;
            tmr_r[gi] <= 16'h0000;
          end else if (indexer && lvl != lvl_r[gi]) begin
            if (lvl > lvl_r[gi]) begin
              ph_r[gi] <= msc_pkg::MSC_ON;
              blk_r[gi] <= blkEff;
            end else begin
              ph_r[gi] <= msc_pkg::MSC_FAST;
              tmr_r[gi] <= offCyc;
              blk_r[gi] <= blkEff;
            end
          end else begin
            case (ph_r[gi])
              msc_pkg::MSC_ON: begin
                if (blk_r[gi] == 16'h0000 && tripCmp[gi]) begin
                  tmr_r[gi] <= offCyc;
                  if (dsel == msc_pkg::MSC_DEC_AUTO) begin
                    ph_r[gi] <= msc_pkg::MSC_AUTOFAST;
                    blk_r[gi] <= blkEff;
                  end else if (dsel == msc_pkg::MSC_DEC_FAST ||
                    (dsel == msc_pkg::MSC_DEC_MIXED && !rising)) begin
                    ph_r[gi] <= msc_pkg::MSC_FAST;
                    blk_r[gi] <= fastCyc;
                  end else begin
                    ph_r[gi] <= msc_pkg::MSC_SLOW;
                  end
                end
              end
              msc_pkg::MSC_FAST: begin
                if (tmr_r[gi] <= 16'h0001) begin
                  ph_r[gi] <= msc_pkg::MSC_ON;
                  blk_r[gi] <= blkEff;
                end else if (dsel == msc_pkg::MSC_DEC_MIXED && blk_r[gi] <= 16'h0001) begin
                  ph_r[gi] <= msc_pkg::MSC_SLOW;
                end
              end
              msc_pkg::MSC_AUTOFAST: begin
                if (tmr_r[gi] <= 16'h0001) begin
                  ph_r[gi] <= msc_pkg::MSC_ON;
                  blk_r[gi] <= blkEff;
                end else if (blk_r[gi] == 16'h0000 && !tripCmp[gi]) begin
                  ph_r[gi] <= msc_pkg::MSC_SLOW;
                end
              end
              default: begin
                if (tmr_r[gi] <= 16'h0001) begin
                  ph_r[gi] <= msc_pkg::MSC_ON;
                  blk_r[gi] <= blkEff;
                end
              end
            endcase
          end
        end
      end
    end
  endgenerate
  // ==========================================================
  // gate decode with dead time and peak window
  logic [3:0] want [2];
  logic [3:0] gat_r [2];
  logic [15:0] dt_r [2];
  logic [15:0] pk_r [2];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // order {hi1, lo1, hi2, lo2}; dir picks which diagonal drives
      case (ph_r[i])
        msc_pkg::MSC_ON: want[i] = drvDir[i] ? 4'b0110 : 4'b1001;
        msc_pkg::MSC_FAST, msc_pkg::MSC_AUTOFAST:
          want[i] = zeroCmp[i] ? 4'b0000 : (drvDir[i] ? 4'b1001 : 4'b0110);
        default: want[i] = 4'b0101;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 2; i++) begin
        gat_r[i] <= 4'b0000;
        dt_r[i] <= 16'h0000;
        pk_r[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pk_r[i] != 16'h0000) pk_r[i] <= pk_r[i] - 16'h0001;
        if (want[i] != gat_r[i]) begin
          if ((gat_r[i] & ~want[i]) != 4'b0000) begin
            // turn-offs go first, then wait dead time
            gat_r[i] <= gat_r[i] & want[i];
            dt_r[i] <= dtCyc;
            pk_r[i] <= drvCyc;
          end else if (dt_r[i] <= 16'h0001) begin
            gat_r[i] <= want[i];
            pk_r[i] <= drvCyc;
            dt_r[i] <= 16'h0000;
          end else begin
            dt_r[i] <= dt_r[i] - 16'h0001;
          end
        end else if (dt_r[i] != 16'h0000) begin
          dt_r[i] <= dt_r[i] - 16'h0001;
        end
      end
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hiGate <= 2'b00;
      loGate <= 2'b00;
      hiGateB <= 2'b00;
      loGateB <= 2'b00;
      peakDrive <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        hiGate[i] <= gat_r[i][3];
        loGate[i] <= gat_r[i][2] & ~gat_r[i][3];
        hiGateB[i] <= gat_r[i][1];
        loGateB[i] <= gat_r[i][0] & ~gat_r[i][1];
        peakDrive[i] <= pk_r[i] != 16'h0000;
      end
    end
  end
  // ==========================================================
  // read port
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      if (regAddr == `MSC_REG_CTRL) regRdata <= ctrl_r;
      else if (regAddr == `MSC_REG_TORQUE) regRdata <= torque_r;
      else if (regAddr == `MSC_REG_OFF) regRdata <= off_r;
      else if (regAddr == `MSC_REG_BLANK) regRdata <= blank_r;
      else if (regAddr == `MSC_REG_DECAY) regRdata <= decay_r;
      else if (regAddr == `MSC_REG_DRIVE) regRdata <= drive_r;
      else if (regAddr == `MSC_REG_STAT) regRdata <= {3'b000, ph_r[1], ph_r[0], angle_r[6:0]};
      else regRdata <= 16'h0000;
    end else begin
      regRdata <= 16'h0000;
    end
  end
  // ==========================================================
  // checks
  a_home_reset: assert property (@(posedge ref_clk) $rose(arst_n) |-> angle_r == `MSC_HOME_ANGLE)
    else $error("angle not home after reset");
  a_step_moves: assert property (@(posedge ref_clk) disable iff (!arst_n)
    stepEv && indexer |=> angle_r != $past(angle_r)) else $error("step lost");
  a_fwd_dir: assert property (@(posedge ref_clk) disable iff (!arst_n)
    stepEv && indexer && fwd && mode == 4'h8 |=> angle_r == 10'($past(angle_r) + 10'h001))
    else $error("forward step wrong");
  a_slow_lows: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ph_r[0] == msc_pkg::MSC_SLOW |-> want[0] == 4'b0101) else $error("slow decay gates");
  a_no_shoot: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !(gat_r[0][3] && gat_r[0][2])) else $error("shoot through");
  a_blank_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    indexer && ph_r[0] == msc_pkg::MSC_ON && blk_r[0] > 16'h0001 && lvl_r[0] == refA
    ##1 indexer && lvl_r[0] == refA
    |-> ph_r[0] == msc_pkg::MSC_ON) else $error("trip seen in blanking");
  a_trip_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
    indexer && ph_r[0] == msc_pkg::MSC_ON && blk_r[0] == 16'h0000 && tripCmp[0]
    && refA == lvl_r[0] |=> ph_r[0] != msc_pkg::MSC_ON && tmr_r[0] == offCyc)
    else $error("trip not chopped");
  a_dead_gap: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(gat_r[0][2]) |=> !gat_r[0][3]) else $error("no dead time");
  c_step: cover property (@(posedge ref_clk) stepEv);
  c_fast: cover property (@(posedge ref_clk) ph_r[0] == msc_pkg::MSC_FAST);
  c_auto: cover property (@(posedge ref_clk) ph_r[1] == msc_pkg::MSC_AUTOFAST);
endmodule : msc_chopper

// ---- dv/msc_bridge_model.sv ----
// Purpose: far-side model of two bridges with their sense comparators
// Assumes: winding current kept as a magnitude; its sign follows the reference sign
// Notes: RISE sets how fast current builds, so a slow or a prompt load can be modelled
`timescale 1ns/1ps
module msc_bridge_model #(
  parameter int RISE = 2
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [1:0] hiGate,
  input wire logic [1:0] loGate,
  input wire logic [1:0] hiGateB,
  input wire logic [1:0] loGateB,
  input wire logic [7:0] refA,
  input wire logic [7:0] refB,
  input wire logic refNegA,
  input wire logic refNegB,
  output logic [1:0] tripCmp,
  output logic [1:0] zeroCmp
);
  int cur [2];
  logic [1:0] neg;
  logic [1:0] drv;
  logic [1:0] rev;
  assign neg = {refNegB, refNegA};
  assign drv = (~neg & hiGate & loGateB) | (neg & hiGateB & loGate);
  assign rev = (~neg & hiGateB & loGate) | (neg & hiGate & loGateB);
  // ==========================================================
  // winding current: builds when driven, falls fast when reversed, slow otherwise
  always_ff @(posedge ref_clk or negedge arst_n) begin
    for (int i = 0; i < 2; i++) begin
      if (!arst_n) begin
        cur[i] <= 0;
      end else if (drv[i]) begin
        cur[i] <= cur[i] + RISE;
      end else if (rev[i]) begin
        cur[i] <= (cur[i] > 4) ? cur[i] - 4 : 0;
      end else if (cur[i] > 0) begin
        cur[i] <= cur[i] - 1;
      end
    end
  end
  // ==========================================================
  // comparators: a zero reference trips at once, as a real sense path would
  always_comb begin
    tripCmp[0] = cur[0] >= 4 * int'(refA);
    tripCmp[1] = cur[1] >= 4 * int'(refB);
    zeroCmp[0] = cur[0] < 4;
    zeroCmp[1] = cur[1] < 4;
  end
endmodule : msc_bridge_model

// ---- dv/msc_chopper_bench.sv ----
// Purpose: self-checking bench for the indexer and chopper
// Assumes: 250 MHz ref_clk, bridge model on the far side
// Notes: register reads are checked through a queue by a separate monitor
`timescale 1ns/1ps
`include "msc_defs.svh"
module msc_chopper_bench;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic stepIn = 1'b0;
  logic dirIn = 1'b1;
  logic [1:0] pwmIn = 2'b00;
  logic [15:0] regRdata;
  logic [1:0] tripCmp, zeroCmp, hiGate, loGate, hiGateB, loGateB;
  logic [1:0] peakDrive, senseGain, peakSrc, peakSink;
  logic [7:0] refA, refB;
  logic refNegA, refNegB;
  logic rdPend = 1'b0;
  logic [1:0] hiPrev = 2'b00;
  logic [15:0] expQ [$];
  int miscompares = 0;
  int cmpCount = 0;
  int cyc = 0;
  always #2 ref_clk = ~ref_clk;
  msc_chopper dut (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .stepIn(stepIn), .dirIn(dirIn), .pwmIn(pwmIn), .tripCmp(tripCmp), .zeroCmp(zeroCmp),
    .hiGate(hiGate), .loGate(loGate), .hiGateB(hiGateB), .loGateB(loGateB),
    .peakDrive(peakDrive), .refA(refA), .refB(refB), .refNegA(refNegA),
    .refNegB(refNegB), .senseGain(senseGain), .peakSrc(peakSrc), .peakSink(peakSink));
  msc_bridge_model far (.ref_clk(ref_clk), .arst_n(arst_n), .hiGate(hiGate),
    .loGate(loGate), .hiGateB(hiGateB), .loGateB(loGateB), .refA(refA), .refB(refB),
    .refNegA(refNegA), .refNegB(refNegB), .tripCmp(tripCmp), .zeroCmp(zeroCmp));
  // ==========================================================
  // checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic closeOut();
    $display("compares %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : closeOut
  // hang guard: the whole run needs about 15000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      closeOut();
    end
  end
  // ==========================================================
  // monitors: read data only stands the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rdPend && expQ.size() == 0) check(regRdata, 16'hxxxx);
    else if (rdPend) check(regRdata, expQ.pop_front());
    rdPend <= regRd;
    hiPrev <= hiGate;
    for (int i = 0; i < 2; i++)
      if (arst_n && hiGate[i] && !hiPrev[i]) check(loGate[i], 1'b0);
  end
  // ==========================================================
  // bus and step drivers
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask : rd
  task automatic pulse();
    @(posedge ref_clk);
    stepIn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    stepIn <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : pulse
  // k counts quarter turns from 45 degrees: equal magnitudes, signs by quadrant
  task automatic quadChk(input int k);
    check(refA, refB);
    check(refNegA, (k == 2 || k == 3));
    check(refNegB, (k == 1 || k == 2));
  endtask : quadChk
  task automatic runChop(input msc_pkg::msc_decay_t dec, input int expSlow, input int expRev);
    int slowN, revN, offRun, maxOff, onRun, minOn;
    slowN = 0;
    revN = 0;
    offRun = 0;
    maxOff = 0;
    onRun = -100000;
    minOn = 100000;
    wr(`MSC_REG_DECAY, {5'h00, dec, 8'h04});
    rd(`MSC_REG_DECAY, {5'h00, dec, 8'h04});
    // let the off phase left by the previous mode run out first
    repeat (600) @(posedge ref_clk);
    repeat (3000) begin
      @(posedge ref_clk);
      if (loGate[0] && loGateB[0]) slowN++;
      if (hiGateB[0] && loGate[0]) revN++;
      if (hiGate[0] && loGateB[0]) begin
        if (offRun > maxOff) maxOff = offRun;
        offRun = 0;
        onRun++;
      end else begin
        // an on run already going when the window opens is skipped, as it started before the window
        if (onRun > 0 && onRun < minOn) minOn = onRun;
        onRun = 0;
        offRun++;
      end
    end
    check(maxOff >= 125, 1'b1);
    check(minOn >= 250, 1'b1);
    if (expSlow < 2) check(slowN > 0, expSlow[0]);
    if (expRev < 2) check(revN > 0, expRev[0]);
  endtask : runChop
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(14));
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(`MSC_REG_CTRL, `MSC_CTRL_RST);
    rd(`MSC_REG_TORQUE, `MSC_TORQUE_RST);
    rd(`MSC_REG_OFF, `MSC_OFF_RST);
    rd(`MSC_REG_BLANK, `MSC_BLANK_RST);
    rd(`MSC_REG_DECAY, `MSC_DECAY_RST);
    rd(`MSC_REG_DRIVE, `MSC_DRIVE_RST);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    repeat (3) @(posedge ref_clk);
    quadChk(0);
    for (int k = 1; k < 5; k++) begin
      pulse();
      quadChk(k % 4);
    end
    dirIn <= 1'b0;
    pulse();
    quadChk(3);
    wr(`MSC_REG_CTRL, 16'h0003);
    pulse();
    quadChk(0);
    dirIn <= 1'b1;
    pulse();
    quadChk(3);
    // a soft step uses the invert bit already held, so clear it first
    wr(`MSC_REG_CTRL, 16'h0001);
    wr(`MSC_REG_CTRL, 16'h0005);
    repeat (4) @(posedge ref_clk);
    quadChk(0);
    wr(`MSC_REG_CTRL, 16'h0000);
    pulse();
    wr(`MSC_REG_CTRL, 16'h0001);
    repeat (4) @(posedge ref_clk);
    quadChk(0);
    pulse();
    quadChk(1);
    // a second reset in mid-run must bring the indexer home again
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    quadChk(0);
    wr(`MSC_REG_CTRL, 16'h0009);
    pulse();
    check(refB, 8'h00);
    check(refNegA, 1'b0);
    wr(`MSC_REG_CTRL, 16'h0019);
    pulse();
    check(refNegB, 1'b1);
    wr(`MSC_REG_CTRL, 16'h0041);
    pulse();
    check(refNegB, 1'b1);
    wr(`MSC_REG_CTRL, 16'h0001);
    pulse();
    quadChk(1);
    for (int g = 0; g < 4; g++) begin
      wr(`MSC_REG_CTRL, 16'(1 | (g << 8)));
      wr(`MSC_REG_DRIVE, 16'((g << 8) | ((3 - g) << 10)));
      repeat (3) @(posedge ref_clk);
      check(senseGain, 16'(g));
      check(peakSrc, 16'(g));
      check(peakSink, 16'(3 - g));
    end
    wr(`MSC_REG_CTRL, 16'h0001);
    wr(`MSC_REG_TORQUE, 16'h0000);
    repeat (4) @(posedge ref_clk);
    check(refA, 8'h00);
    check(refB, 8'h00);
    regWdata <= 16'($urandom_range(255, 128));
    pwmIn <= 2'($urandom);
    @(posedge ref_clk);
    wr(`MSC_REG_TORQUE, regWdata);
    rd(`MSC_REG_TORQUE, regWdata);
    wr(`MSC_REG_OFF, 16'h0001);
    rd(`MSC_REG_OFF, 16'h0001);
    runChop(msc_pkg::MSC_DEC_SLOW, 1, 0);
    runChop(msc_pkg::MSC_DEC_FAST, 0, 1);
    runChop(msc_pkg::MSC_DEC_MIXED, 1, 0);
    runChop(msc_pkg::MSC_DEC_AUTO, 2, 2);
    repeat (4) @(posedge ref_clk);
    closeOut();
  end
endmodule : msc_chopper_bench
